// [hdl/csor_pkg.sv]
/*
 Constants for the configuration strap override register block.
 Assumes an 8-bit register port and one 10 MHz board-logic clock.
*/
// Contract
// (R1) Voltage enable selects voltage ID source
// (R2) Core PLL enable selects both core ratios
// (R3) Platform PLL enable selects platform ratio
// (R4) Clock enable selects programmed clock words
// (R5) Memory PLL enable selects memory ratio; the code selects it with EN_PLATFORM_PLL_OVERRIDE_EN (bit 7)
// (R6) Serial-link enable selects four-bit link mode
// (R7) Board-logic enable selects two-bit strap
// (R8) Host enable selects three-bit host role
// (R9) Flash enable selects flash map
// (R10) Boot-sequence enable selects boot sequence strap
// (R11) Boot-location enable selects boot location strap
// (R12) Voltage register reads live bus, gated writes
// (R13) Voltage ID bits mapped reversed
// (R14) Flash map reads live, gated writes
// (R15) Boot sequence reads live, own enable
// (R16) Boot location reads live, gated writes
// (R17) First core ratio readback, gated write
// (R18) Second core ratio readback, gated write
// (R19) Memory ratio readback, gated write
// (R20) Platform ratio readback, gated write
// (R21) Override enables clear at reset
// (R22) Reserved bits read zero, ignore writes
package csor_pkg;
    localparam logic [3:0] ADDR_EN_A = 4'h0;
    localparam logic [3:0] ADDR_EN_B = 4'h1;
    localparam logic [3:0] ADDR_VOLT = 4'h2;
    localparam logic [3:0] ADDR_BOOT = 4'h3;
    localparam logic [3:0] ADDR_CORE = 4'h4;
    localparam logic [3:0] ADDR_PLAT = 4'h5;
    localparam logic [3:0] ADDR_HOST = 4'h6;
    localparam logic [3:0] ADDR_SYSW0 = 4'h7;
    localparam logic [3:0] ADDR_MEMW0 = 4'ha;
    localparam int CLK_WORDS = 3;
    // Enable A bits
    localparam int EN_VOLT = 0;
    localparam int EN_CORE_PLL_OVERRIDE_EN = 3;
    localparam int EN_PPLL = 4;
    localparam int EN_CLK = 5;
    localparam int EN_PLATFORM_PLL_OVERRIDE_EN = 7;
    localparam logic [7:0] EN_A_MASK = 8'hb9;
    // Enable B bits
    localparam int EN_LINK = 2;
    localparam int EN_BRD = 3;
    localparam int EN_HOST = 4;
    localparam int EN_FLASH = 5;
    localparam int EN_BSEQ = 6;
    localparam int EN_BLOC = 7;
    localparam logic [7:0] EN_B_MASK = 8'hfc;
    localparam logic [7:0] RESET_EN = 8'h00;
    localparam logic [7:0] RESET_VAL = 8'h00;
endpackage

// [hdl/csor_field_mux.sv]
/*
 One strap group: holds the software value and selects the strap source.
 Assumes switch inputs already synchronised by the caller.
*/
`timescale 1ns/100ps
module csor_field_mux #(
    parameter int W = 1
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic en_in,
    input wire logic wr_in,
    input wire logic [W-1:0] wdata_in,
    input wire logic [W-1:0] switch_in,
    output logic [W-1:0] strap_out
);
    logic [W-1:0] val_q;

    // Write lands only while override enabled
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            val_q <= '0;
        end else if (wr_in && en_in) begin
            val_q <= wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            strap_out <= '0;
        end else begin
            strap_out <= en_in ? val_q : switch_in;
        end
    end
endmodule

// [hdl/csor_regs.sv]
/*
 Strap override register bank: enables, strap values, clock words.
 Assumes switch inputs are asynchronous pins and a one-cycle strobe bus.
*/
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/100ps
module csor_regs (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [6:0] voltage_id_sw_in,
    input wire logic [2:0] first_core_ratio_sw_in,
    input wire logic [2:0] second_core_ratio_sw_in,
    input wire logic [2:0] platform_ratio_sw_in,
    input wire logic [3:0] memory_ratio_sw_in,
    input wire logic [3:0] link_mode_sw_in,
    input wire logic [1:0] board_logic_sw_in,
    input wire logic [2:0] host_role_sw_in,
    input wire logic [1:0] flash_map_sw_in,
    input wire logic [1:0] boot_sequence_sw_in,
    input wire logic [3:0] boot_location_sw_in,
    output logic [6:0] voltage_id_strap_out,
    output logic [2:0] first_core_ratio_strap_out,
    output logic [2:0] second_core_ratio_strap_out,
    output logic [2:0] platform_ratio_strap_out,
    output logic [3:0] memory_ratio_strap_out,
    output logic [3:0] link_mode_strap_out,
    output logic [1:0] board_logic_strap_out,
    output logic [2:0] host_role_strap_out,
    output logic [1:0] flash_map_strap_out,
    output logic [1:0] boot_sequence_strap_out,
    output logic [3:0] boot_location_strap_out,
    output logic clock_word_sel_out,
    output logic [23:0] system_clock_word_out,
    output logic [23:0] memory_clock_word_out
);
    localparam int SW_W = 37;

    logic [SW_W-1:0] sw_meta_q;
    logic [SW_W-1:0] sw_sync_q;
    logic [7:0] en_a_q;
    logic [7:0] en_b_q;
    logic [7:0] sys_word_q [csor_pkg::CLK_WORDS];
    logic [7:0] mem_word_q [csor_pkg::CLK_WORDS];
    logic [7:0] rdata_d;
    logic [6:0] volt_sw;
    logic [2:0] core0_sw;
    logic [2:0] core1_sw;
    logic [2:0] plat_sw;
    logic [3:0] mem_sw;
    logic [3:0] link_sw;
    logic [1:0] brd_sw;
    logic [2:0] host_sw;
    logic [1:0] flash_sw;
    logic [1:0] bseq_sw;
    logic [3:0] bloc_sw;
    logic wr_volt;
    logic wr_boot;
    logic wr_core;
    logic wr_plat;
    logic wr_host;

    function automatic logic [6:0] rev7(input logic [6:0] v);
        logic [6:0] r;
        r = '0;
        for (int i = 0; i < 7; i++) begin
            r[i] = v[6-i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Switch synchronisers
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            sw_meta_q <= '0;
            sw_sync_q <= '0;
        end else begin
            sw_meta_q <= {voltage_id_sw_in, first_core_ratio_sw_in,
                second_core_ratio_sw_in, platform_ratio_sw_in, memory_ratio_sw_in,
                link_mode_sw_in, board_logic_sw_in, host_role_sw_in,
                flash_map_sw_in, boot_sequence_sw_in, boot_location_sw_in};
            sw_sync_q <= sw_meta_q;
        end
    end

    assign {volt_sw, core0_sw, core1_sw, plat_sw, mem_sw, link_sw, brd_sw,
        host_sw, flash_sw, bseq_sw, bloc_sw} = sw_sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    assign wr_volt = wr_in && (addr_in == csor_pkg::ADDR_VOLT);
    assign wr_boot = wr_in && (addr_in == csor_pkg::ADDR_BOOT);
    assign wr_core = wr_in && (addr_in == csor_pkg::ADDR_CORE);
    assign wr_plat = wr_in && (addr_in == csor_pkg::ADDR_PLAT);
    assign wr_host = wr_in && (addr_in == csor_pkg::ADDR_HOST);

    // Override enables
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            en_a_q <= csor_pkg::RESET_EN; // R21
            en_b_q <= csor_pkg::RESET_EN; // R21
        end else if (wr_in && addr_in == csor_pkg::ADDR_EN_A) begin
            en_a_q <= wdata_in & csor_pkg::EN_A_MASK; // R22
        end else if (wr_in && addr_in == csor_pkg::ADDR_EN_B) begin
            en_b_q <= wdata_in & csor_pkg::EN_B_MASK; // R22
        end
    end

    // Clock generator words
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < csor_pkg::CLK_WORDS; i++) begin
                sys_word_q[i] <= csor_pkg::RESET_VAL;
                mem_word_q[i] <= csor_pkg::RESET_VAL;
            end
        end else if (wr_in) begin
            for (int i = 0; i < csor_pkg::CLK_WORDS; i++) begin
                if (addr_in == csor_pkg::ADDR_SYSW0 + 4'(i)) begin
                    sys_word_q[i] <= wdata_in;
                end
                if (addr_in == csor_pkg::ADDR_MEMW0 + 4'(i)) begin
                    mem_word_q[i] <= wdata_in;
                end
            end
        end
    end

    assign clock_word_sel_out = en_a_q[csor_pkg::EN_CLK]; // R4
    assign system_clock_word_out = {sys_word_q[0], sys_word_q[1], sys_word_q[2]};
    assign memory_clock_word_out = {mem_word_q[0], mem_word_q[1], mem_word_q[2]};

    ////////////////////////////////////////////////////////////////////////
    // Strap groups
    csor_field_mux #(.W(7)) u_volt (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_a_q[csor_pkg::EN_VOLT]), // R1 R12
        .wr_in(wr_volt),
        .wdata_in(rev7(wdata_in[7:1])), // R13
        .switch_in(volt_sw), .strap_out(voltage_id_strap_out));

    csor_field_mux #(.W(3)) u_core0 (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_a_q[csor_pkg::EN_CORE_PLL_OVERRIDE_EN]), // R2 R17
        .wr_in(wr_core), .wdata_in(wdata_in[2:0]),
        .switch_in(core0_sw), .strap_out(first_core_ratio_strap_out));

    csor_field_mux #(.W(3)) u_core1 (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_a_q[csor_pkg::EN_CORE_PLL_OVERRIDE_EN]), // R2 R18
        .wr_in(wr_core), .wdata_in(wdata_in[5:3]),
        .switch_in(core1_sw), .strap_out(second_core_ratio_strap_out));

    csor_field_mux #(.W(3)) u_plat (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_a_q[csor_pkg::EN_PPLL]), // R3 R20
        .wr_in(wr_plat), .wdata_in(wdata_in[7:5]),
        .switch_in(plat_sw), .strap_out(platform_ratio_strap_out));

    csor_field_mux #(.W(4)) u_mem (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_a_q[csor_pkg::EN_PLATFORM_PLL_OVERRIDE_EN]), // R5 R19
        .wr_in(wr_plat), .wdata_in({1'b0, wdata_in[4:2]}),
        .switch_in(mem_sw), .strap_out(memory_ratio_strap_out));

    csor_field_mux #(.W(4)) u_link (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_b_q[csor_pkg::EN_LINK]), // R6
        .wr_in(wr_host), .wdata_in(wdata_in[7:4]),
        .switch_in(link_sw), .strap_out(link_mode_strap_out));

    csor_field_mux #(.W(2)) u_brd (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_b_q[csor_pkg::EN_BRD]), // R7
        .wr_in(wr_core), .wdata_in(wdata_in[7:6]),
        .switch_in(brd_sw), .strap_out(board_logic_strap_out));

    csor_field_mux #(.W(3)) u_host (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_b_q[csor_pkg::EN_HOST]), // R8
        .wr_in(wr_host), .wdata_in(wdata_in[2:0]),
        .switch_in(host_sw), .strap_out(host_role_strap_out));

    csor_field_mux #(.W(2)) u_flash (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_b_q[csor_pkg::EN_FLASH]), // R9 R14
        .wr_in(wr_boot), .wdata_in(wdata_in[1:0]),
        .switch_in(flash_sw), .strap_out(flash_map_strap_out));

    csor_field_mux #(.W(2)) u_bseq (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_b_q[csor_pkg::EN_BSEQ]), // R10 R15
        .wr_in(wr_boot), .wdata_in(wdata_in[3:2]),
        .switch_in(bseq_sw), .strap_out(boot_sequence_strap_out));

    csor_field_mux #(.W(4)) u_bloc (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .en_in(en_b_q[csor_pkg::EN_BLOC]), // R11 R16
        .wr_in(wr_boot), .wdata_in(wdata_in[7:4]),
        .switch_in(bloc_sw), .strap_out(boot_location_strap_out));

    ////////////////////////////////////////////////////////////////////////
    // Readback of live straps
    always_comb begin
        rdata_d = 8'h00; // R22
        case (addr_in)
            csor_pkg::ADDR_EN_A: rdata_d = en_a_q;
            csor_pkg::ADDR_EN_B: rdata_d = en_b_q;
            csor_pkg::ADDR_VOLT: rdata_d = {rev7(voltage_id_strap_out), 1'b0}; // R12
            csor_pkg::ADDR_BOOT: rdata_d = {boot_location_strap_out,
                boot_sequence_strap_out, flash_map_strap_out}; // R14
            csor_pkg::ADDR_CORE: rdata_d = {board_logic_strap_out,
                second_core_ratio_strap_out, first_core_ratio_strap_out}; // R17
            csor_pkg::ADDR_PLAT: rdata_d = {platform_ratio_strap_out,
                memory_ratio_strap_out[2:0], 2'b00}; // R19
            csor_pkg::ADDR_HOST: rdata_d = {link_mode_strap_out, 1'b0,
                host_role_strap_out};
            csor_pkg::ADDR_SYSW0: rdata_d = sys_word_q[0];
            csor_pkg::ADDR_SYSW0 + 4'h1: rdata_d = sys_word_q[1];
            csor_pkg::ADDR_SYSW0 + 4'h2: rdata_d = sys_word_q[2];
            csor_pkg::ADDR_MEMW0: rdata_d = mem_word_q[0];
            csor_pkg::ADDR_MEMW0 + 4'h1: rdata_d = mem_word_q[1];
            csor_pkg::ADDR_MEMW0 + 4'h2: rdata_d = mem_word_q[2];
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            rdata_out <= rdata_d;
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule

// [verif/csor_switch_bank.sv]
/*
 Model of the board switch bank feeding the strap override block.
 Assumes the bench picks an 8-bit pattern that is spread over all groups.
*/
`timescale 1ns/100ps
module csor_switch_bank (
    input wire logic ref_clk_in,
    input wire logic [7:0] pat_in,
    output logic [36:0] sw_out
);
    initial sw_out = 37'h0;
    // Switches move on the edge itself, by nonblocking assignment with no delay
    always @(posedge ref_clk_in) begin
        sw_out <= {pat_in[4:0], pat_in, pat_in, pat_in, pat_in};
    end
endmodule

// [verif/csor_regs_props.sv]
/*
 Assertions on the strap override register block ports.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module csor_regs_props (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [6:0] voltage_id_sw_in,
    input wire logic [3:0] boot_location_sw_in,
    input wire logic [6:0] voltage_id_strap_out,
    input wire logic [1:0] flash_map_strap_out,
    input wire logic [1:0] boot_sequence_strap_out,
    input wire logic [3:0] boot_location_strap_out,
    input wire logic clock_word_sel_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] en_a_q, en_b_q;
    logic [2:0] up_q;
    // Shadow enables and settle counter
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            en_a_q <= 8'h00;
            en_b_q <= 8'h00;
            up_q <= 3'h0;
        end else begin
            if (up_q != 3'h7) up_q <= up_q + 3'h1;
            if (wr_in && addr_in == csor_pkg::ADDR_EN_A) en_a_q <= wdata_in;
            if (wr_in && addr_in == csor_pkg::ADDR_EN_B) en_b_q <= wdata_in;
        end
    end
    AST_EN_A_RSV: assert property ($past(rd_in) && $past(addr_in) == csor_pkg::ADDR_EN_A
        |-> (rdata_out & ~csor_pkg::EN_A_MASK) == 8'h00) else $error("enable a reserved set");
    AST_EN_B_RSV: assert property ($past(rd_in) && $past(addr_in) == csor_pkg::ADDR_EN_B
        |-> (rdata_out & ~csor_pkg::EN_B_MASK) == 8'h00) else $error("enable b reserved set");
    AST_VOLT_RD: assert property ($past(rd_in)
        && $past(addr_in) == csor_pkg::ADDR_VOLT
        |-> {rdata_out[1], rdata_out[2], rdata_out[3], rdata_out[4], rdata_out[5],
        rdata_out[6], rdata_out[7], rdata_out[0]} == {$past(voltage_id_strap_out), 1'b0})
        else $error("voltage read wrong");
    AST_BOOT_RD: assert property ($past(rd_in)
        && $past(addr_in) == csor_pkg::ADDR_BOOT
        |-> rdata_out == {$past(boot_location_strap_out), $past(boot_sequence_strap_out),
        $past(flash_map_strap_out)}) else $error("boot read wrong");
    AST_VOLT_SW: assert property (up_q == 3'h7 && !en_a_q[0] && !$past(en_a_q[0])
        && !$past(en_a_q[0], 2) |-> voltage_id_strap_out == $past(voltage_id_sw_in, 3))
        else $error("voltage not from switches");
    AST_BLOC_SW: assert property (up_q == 3'h7 && !en_b_q[7] && !$past(en_b_q[7])
        && !$past(en_b_q[7], 2) |-> boot_location_strap_out == $past(boot_location_sw_in, 3))
        else $error("boot location not from switches");
    AST_VOLT_HOLD: assert property (en_a_q[0] && $past(en_a_q[0]) && $past(en_a_q[0], 2)
        && !$past(wr_in) && !$past(wr_in, 2) |-> $stable(voltage_id_strap_out))
        else $error("override voltage moved");
    AST_CLK_SEL: assert property ($stable(en_a_q[5]) |-> clock_word_sel_out == en_a_q[5])
        else $error("clock word select wrong");
    AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside read");
endmodule
bind csor_regs csor_regs_props u_csor_regs_props (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .voltage_id_sw_in(voltage_id_sw_in),
    .boot_location_sw_in(boot_location_sw_in), .voltage_id_strap_out(voltage_id_strap_out),
    .flash_map_strap_out(flash_map_strap_out),
    .boot_sequence_strap_out(boot_sequence_strap_out),
    .boot_location_strap_out(boot_location_strap_out),
    .clock_word_sel_out(clock_word_sel_out));

// [verif/csor_regs_tb.sv]
/*
 Register-level bench for the strap override block.
 Assumes the switch bank model and the bound checker.
*/
`timescale 1ns/100ps
module csor_regs_tb;
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("Error at %0t: got %h want %h", $time, g, e); \
    end \
end
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] pat = 8'h00;
    logic [36:0] sw;
    logic [7:0] rdata_out;
    logic [6:0] voltage_id;
    logic [2:0] c0, c1, pl, hr;
    logic [3:0] mr, lk, bl;
    logic [1:0] bd, fm, bs;
    logic sel;
    logic [23:0] sysw, memw;
    int fails = 0;
    int samples_checked = 0;
    initial forever #50 ref_clk_in = ~ref_clk_in;
    csor_switch_bank u_csor_switch_bank (.ref_clk_in(ref_clk_in), .pat_in(pat), .sw_out(sw));
    csor_regs u_csor_regs (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .voltage_id_sw_in(sw[6:0]), .first_core_ratio_sw_in(sw[9:7]),
        .second_core_ratio_sw_in(sw[12:10]), .platform_ratio_sw_in(sw[15:13]),
        .memory_ratio_sw_in(sw[19:16]), .link_mode_sw_in(sw[23:20]),
        .board_logic_sw_in(sw[25:24]), .host_role_sw_in(sw[28:26]),
        .flash_map_sw_in(sw[30:29]), .boot_sequence_sw_in(sw[32:31]),
        .boot_location_sw_in(sw[36:33]), .voltage_id_strap_out(voltage_id),
        .first_core_ratio_strap_out(c0), .second_core_ratio_strap_out(c1),
        .platform_ratio_strap_out(pl), .memory_ratio_strap_out(mr), .link_mode_strap_out(lk),
        .board_logic_strap_out(bd), .host_role_strap_out(hr), .flash_map_strap_out(fm),
        .boot_sequence_strap_out(bs), .boot_location_strap_out(bl), .clock_word_sel_out(sel),
        .system_clock_word_out(sysw), .memory_clock_word_out(memw));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        rd_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        wr_in <= 1'b0;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        `CHK(rdata_out, e)
    endtask
    task automatic idle(input int n);
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask
    task automatic chk_sw();
        `CHK(voltage_id, sw[6:0])
        `CHK({c1, c0}, sw[12:7])
        `CHK({mr, pl}, sw[19:13])
        `CHK({hr, bd, lk}, sw[28:20])
        `CHK({bl, bs, fm}, sw[36:29])
        `CHK(sel, 1'b0)
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        pat <= 8'ha5;
        rd(csor_pkg::ADDR_EN_A, 8'h00);
        rd(csor_pkg::ADDR_EN_B, 8'h00);
        rd(4'hf, 8'h00);
        wr(csor_pkg::ADDR_VOLT, 8'h5b);
        wr(csor_pkg::ADDR_BOOT, 8'hff);
        idle(4);
        chk_sw();
        wr(csor_pkg::ADDR_EN_A, 8'hff);
        wr(csor_pkg::ADDR_EN_B, 8'hff);
        rd(csor_pkg::ADDR_EN_A, 8'hb9);
        rd(csor_pkg::ADDR_EN_B, 8'hfc);
        idle(4);
        `CHK({voltage_id, bl}, 11'h000)
        wr(csor_pkg::ADDR_VOLT, 8'h5b);
        wr(csor_pkg::ADDR_BOOT, 8'h6d);
        wr(csor_pkg::ADDR_CORE, 8'hea);
        wr(csor_pkg::ADDR_PLAT, 8'hb7);
        wr(csor_pkg::ADDR_HOST, 8'ha5);
        for (int i = 0; i < 6; i++) begin
            wr(csor_pkg::ADDR_SYSW0 + 4'(i), 8'h12 + 8'(8'h11 * i));
        end
        idle(4);
        `CHK(voltage_id, 7'h5a)
        `CHK({bl, bs, fm}, 8'h6d)
        `CHK({bd, c1, c0}, 8'hea)
        `CHK({mr, pl}, 7'h2d)
        `CHK({lk, hr}, 7'h55)
        `CHK({sel, sysw, memw}, 49'h1_1223_3445_5667)
        rd(csor_pkg::ADDR_VOLT, 8'h5a);
        rd(csor_pkg::ADDR_BOOT, 8'h6d);
        rd(csor_pkg::ADDR_CORE, 8'hea);
        rd(csor_pkg::ADDR_PLAT, 8'hb4);
        rd(csor_pkg::ADDR_HOST, 8'ha5);
        rd(csor_pkg::ADDR_SYSW0, 8'h12);
        rd(csor_pkg::ADDR_MEMW0 + 4'h2, 8'h67);
        wr(csor_pkg::ADDR_EN_A, 8'h00);
        wr(csor_pkg::ADDR_EN_B, 8'h00);
        pat <= 8'h3c;
        wr(csor_pkg::ADDR_BOOT, 8'h00);
        idle(5);
        chk_sw();
        wr(csor_pkg::ADDR_EN_B, 8'h80);
        idle(4);
        `CHK({bl, bs, fm}, {4'h6, sw[32:29]})
        // Reset in mid-run with an override still active
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd(csor_pkg::ADDR_EN_B, 8'h00);
        idle(4);
        `CHK(bl, sw[36:33])
        close_out();
    end
endmodule
